// >>> verilog/sviu_top.v
// Behaviour
// - One interrupt level, one shared vector, six independent sources.
// - Each source has its own enable bit gating its service request.
// - Source events set pending flags regardless of the enable bit.
// - Enabled pending interrupt is taken only at an instruction end.
// - Acceptance injects a call to address 001 and sets in-service.
// - In-service clears in the instruction after return from interrupt.
// - Requests are level sensitive; a kept flag re-requests after return.
// - Enable bits: timer2 6, comparator 5, timer0 4, pins 2,1,0.
// - Timer 2 overflow sets pending bit 6.
// - Comparator rising or falling output sets pending bit 5.
// - Timer 0 overflow sets pending bit 4.
// - External pin 2 falling edge sets pending bit 2.
// - External pin 1 falling edge sets pending bit 1.
// - Pin 0 sets bit 0 on edge picked by write-only select.
// - Writing zero to a pending bit clears that flag.
`include "sviu_consts.vh"

module sviu_top (
  input  wire                        sys_clk_in,
  input  wire                        reset_n_in,
  // Special function register port
  input  wire [11:0]                 reg_addr_in,
  input  wire                        reg_wr_in,
  input  wire                        reg_rd_in,
  input  wire [7:0]                  reg_wdata_in,
  output wire [7:0]                  reg_rdata_out,
  // Write-only control space port
  input  wire [7:0]                  ctrl_addr_in,
  input  wire                        ctrl_wr_in,
  input  wire [7:0]                  ctrl_wdata_in,
  // Event sources
  input  wire                        timer2_ovf_in,
  input  wire                        timer0_ovf_in,
  input  wire                        comparator_in,
  input  wire                        ext_pin2_in,
  input  wire                        ext_pin1_in,
  input  wire                        ext_pin0_in,
  // CPU sequencer
  input  wire                        instr_end_in,
  input  wire                        return_from_irq_in,
  output wire                        irq_call_out,
  output wire [`SVIU_VEC_WIDTH-1:0]  irq_vector_out,
  output wire                        in_service_out,
  output wire                        irq_request_out,
  output wire [7:0]                  irq_pending_out,
  output wire                        ext_pin0_edge_sel_out
);

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer states and edge lanes

  // Binary codes; the spare code falls back to idle
  localparam [1:0] ST_IDLE        = 2'h0;
  localparam [1:0] ST_IN_SERVICE  = 2'h1;
  localparam [1:0] ST_POST_RETURN = 2'h2;

  // Lane numbers inside the edge detector bank
  localparam integer LANE_CMP   = 0;
  localparam integer LANE_PIN2  = 1;
  localparam integer LANE_PIN1  = 2;
  localparam integer LANE_PIN0  = 3;
  localparam integer LANE_COUNT = 4;

  ////////////////////////////////////////////////////////////////////////////
  // Address decoding

  function is_addr;
    input [11:0] addr;
    input [11:0] target;
    begin
      is_addr = (addr == target);
    end
  endfunction

  function [7:0] impl_bits;
    input [7:0] value;
    begin
      impl_bits = value & `SVIU_IMPL_MASK;
    end
  endfunction

  // One place decides which edge of a pin lane counts as an event
  function edge_hit;
    input sel_rise;
    input rise;
    input fall;
    begin
      edge_hit = sel_rise ? rise : fall;
    end
  endfunction

  wire enable_wr;
  wire pending_wr;
  wire edge_sel_wr;
  wire enable_rd;
  wire pending_rd;

  assign enable_wr   = reg_wr_in & is_addr(reg_addr_in, `SVIU_ADDR_IRQ_ENABLE);
  assign pending_wr  = reg_wr_in & is_addr(reg_addr_in, `SVIU_ADDR_IRQ_PENDING);
  assign enable_rd   = reg_rd_in & is_addr(reg_addr_in, `SVIU_ADDR_IRQ_ENABLE);
  assign pending_rd  = reg_rd_in & is_addr(reg_addr_in, `SVIU_ADDR_IRQ_PENDING);
  assign edge_sel_wr = ctrl_wr_in & is_addr({4'h0, ctrl_addr_in}, {4'h0, `SVIU_ADDR_MISC_CTRL});

  ////////////////////////////////////////////////////////////////////////////
  // Edge detection on level sources

  wire [LANE_COUNT-1:0] level_vec;
  wire [LANE_COUNT-1:0] rise_vec;
  wire [LANE_COUNT-1:0] fall_vec;

  assign level_vec[LANE_CMP]  = comparator_in;
  assign level_vec[LANE_PIN2] = ext_pin2_in;
  assign level_vec[LANE_PIN1] = ext_pin1_in;
  assign level_vec[LANE_PIN0] = ext_pin0_in;

  genvar gi;
  generate
    for (gi = 0; gi < LANE_COUNT; gi = gi + 1) begin : g_edge
      sviu_edge_det #(
        .RESET_LEVEL (1'h1)
      ) u_edge (
        .sys_clk_in (sys_clk_in),
        .reset_n_in (reset_n_in),
        .level_in   (level_vec[gi]),
        .rise_out   (rise_vec[gi]),
        .fall_out   (fall_vec[gi])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Edge select for pin 0

  reg edge_sel_q;
  reg edge_sel_d;

  always @* begin
    edge_sel_d = edge_sel_q;
    if (edge_sel_wr) begin
      edge_sel_d = ctrl_wdata_in[`SVIU_BIT_EDGE_SEL];
    end
  end

  always @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      edge_sel_q <= `SVIU_RST_EDGE_SEL;
    end else begin
      edge_sel_q <= edge_sel_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Hardware set events

  reg [7:0] hw_set;

  // Events are gathered ungated; the enable only matters for requests.
  always @* begin
    hw_set = 8'h00;
    hw_set[`SVIU_BIT_TIMER2]     = timer2_ovf_in;
    hw_set[`SVIU_BIT_COMPARATOR] = rise_vec[LANE_CMP] | fall_vec[LANE_CMP];
    hw_set[`SVIU_BIT_TIMER0]     = timer0_ovf_in;
    hw_set[`SVIU_BIT_EXT_PIN2]   = edge_hit(1'h0, rise_vec[LANE_PIN2],
                                            fall_vec[LANE_PIN2]);
    hw_set[`SVIU_BIT_EXT_PIN1]   = edge_hit(1'h0, rise_vec[LANE_PIN1],
                                            fall_vec[LANE_PIN1]);
    hw_set[`SVIU_BIT_EXT_PIN0]   = edge_hit(edge_sel_q, rise_vec[LANE_PIN0],
                                            fall_vec[LANE_PIN0]);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Enable register

  reg [7:0] enable_q;
  reg [7:0] enable_d;

  always @* begin
    enable_d = enable_q;
    if (enable_wr) begin
      enable_d = impl_bits(reg_wdata_in);
    end
  end

  always @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      enable_q <= `SVIU_RST_IRQ_ENABLE;
    end else begin
      enable_q <= enable_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pending register

  reg  [7:0] pending_q;
  wire [7:0] pending_d;
  wire [7:0] sw_clear;

  // A write clears only the bits written as zero; ones keep their flag.
  assign sw_clear = pending_wr ? ~reg_wdata_in : 8'h00;

  generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_pend
      if (((`SVIU_IMPL_MASK >> gi) & 8'h01) != 8'h00) begin : g_impl
        // Set wins over a clear arriving in the same cycle
        assign pending_d[gi] = hw_set[gi] | (pending_q[gi] & ~sw_clear[gi]);
      end else begin : g_absent
        assign pending_d[gi] = 1'h0;
      end
    end
  endgenerate

  always @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      pending_q <= `SVIU_RST_IRQ_PENDING;
    end else begin
      pending_q <= pending_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Request and entry sequencer

  wire       any_request;
  reg  [1:0] state_q;
  reg  [1:0] state_d;
  reg        call_d;
  reg        call_q;

  // Level sensitive: any enabled flag still set keeps asking.
  assign any_request = |(pending_q & enable_q);

  always @* begin
    state_d = state_q;
    call_d  = 1'h0;
    case (state_q)
      ST_IDLE: begin
        if (instr_end_in && any_request) begin
          call_d  = 1'h1;
          state_d = ST_IN_SERVICE;
        end
      end
      ST_IN_SERVICE: begin
        // Nesting blocked; instruction ends are ignored here
        // The return's own instruction end is swallowed with it
        if (return_from_irq_in) begin
          state_d = ST_POST_RETURN;
        end
      end
      ST_POST_RETURN: begin
        // Still blocked, so one main program instruction always runs
        if (instr_end_in) begin
          state_d = ST_IDLE;
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  always @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state_q <= ST_IDLE;
      call_q  <= 1'h0;
    end else begin
      state_q <= state_d;
      call_q  <= call_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register read-back

  reg [7:0] rdata_q;
  reg [7:0] rdata_d;

  // Unmapped reads return zero; read data hold until the next read.
  always @* begin
    rdata_d = rdata_q;
    if (enable_rd) begin
      rdata_d = impl_bits(enable_q);
    end else if (pending_rd) begin
      rdata_d = impl_bits(pending_q);
    end else if (reg_rd_in) begin
      rdata_d = 8'h00;
    end
  end

  always @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output flops

  reg                       in_service_q;
  reg                       in_service_d;
  reg                       request_q;
  reg                       request_d;
  reg [`SVIU_VEC_WIDTH-1:0] vector_q;
  reg [`SVIU_VEC_WIDTH-1:0] vector_d;

  // Request follows the flags as they will stand, so both move together
  always @* begin
    in_service_d = (state_d != ST_IDLE);
    request_d    = |(pending_d & enable_d);
    vector_d     = `SVIU_IRQ_VECTOR;
  end

  always @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      in_service_q <= 1'h0;
      request_q    <= 1'h0;
    end else begin
      in_service_q <= in_service_d;
      request_q    <= request_d;
    end
  end

  // Fixed vector, still flopped so every output leaves from a register
  always @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      vector_q <= `SVIU_IRQ_VECTOR;
    end else begin
      vector_q <= vector_d;
    end
  end

  assign reg_rdata_out         = rdata_q;
  assign irq_call_out          = call_q;
  assign irq_vector_out        = vector_q;
  assign in_service_out        = in_service_q;
  assign irq_request_out       = request_q;
  assign irq_pending_out       = pending_q;
  assign ext_pin0_edge_sel_out = edge_sel_q;

endmodule // sviu_top

// >>> verilog/sviu_consts.vh
`ifndef SVIU_CONSTS_VH
`define SVIU_CONSTS_VH

// Register addresses in the special function space
`define SVIU_ADDR_IRQ_ENABLE    12'hf08
`define SVIU_ADDR_IRQ_PENDING   12'hf09
// Write-only control space address
`define SVIU_ADDR_MISC_CTRL     8'h0b

// Field positions, shared by enable and pending registers; edge select is a control space bit
`define SVIU_BIT_TIMER2         6
`define SVIU_BIT_COMPARATOR     5
`define SVIU_BIT_TIMER0         4
`define SVIU_BIT_EXT_PIN2       2
`define SVIU_BIT_EXT_PIN1       1
`define SVIU_BIT_EXT_PIN0       0
`define SVIU_BIT_EDGE_SEL       4

// Implemented bits; bits 7 and 3 are absent
`define SVIU_IMPL_MASK          8'h77

// Reset values
`define SVIU_RST_IRQ_ENABLE     8'h00
`define SVIU_RST_IRQ_PENDING    8'h00
`define SVIU_RST_EDGE_SEL       1'h0

// Shared interrupt vector in program memory
`define SVIU_VEC_WIDTH          11
`define SVIU_IRQ_VECTOR         11'h001

`endif

// >>> verilog/sviu_edge_det.v
`include "sviu_consts.vh"

module sviu_edge_det #(
  parameter [0:0] RESET_LEVEL = 1'h1
) (
  input  wire sys_clk_in,
  input  wire reset_n_in,
  input  wire level_in,
  output wire rise_out,
  output wire fall_out
);

  reg level_q;
  reg primed_q;

  // First sample after reset only primes the history, so a level that
  // differs from the reset guess does not fake an edge.
  always @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      level_q  <= RESET_LEVEL;
      primed_q <= 1'h0;
    end else begin
      level_q  <= level_in;
      primed_q <= 1'h1;
    end
  end

  assign rise_out = primed_q & level_in & ~level_q;
  assign fall_out = primed_q & ~level_in & level_q;

endmodule // sviu_edge_det

// >>> sim/sviu_top_props.sv
module sviu_top_props (
  input wire logic        sys_clk_in,
  input wire logic        reset_n_in,
  input wire logic [11:0] reg_addr_in,
  input wire logic        reg_wr_in,
  input wire logic [7:0]  reg_wdata_in,
  input wire logic [7:0]  ctrl_addr_in,
  input wire logic        ctrl_wr_in,
  input wire logic [7:0]  ctrl_wdata_in,
  input wire logic        timer2_ovf_in,
  input wire logic        timer0_ovf_in,
  input wire logic        instr_end_in,
  input wire logic        irq_call_out,
  input wire logic [10:0] irq_vector_out,
  input wire logic        in_service_out,
  input wire logic        irq_request_out,
  input wire logic [7:0]  irq_pending_out,
  input wire logic        ext_pin0_edge_sel_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!reset_n_in);
  ////////////////////////////////////////
  property p_vec; irq_vector_out == 11'h001; endproperty
  a_vec: assert property (p_vec) else $error("bad vector");
  property p_acc;
    instr_end_in && !in_service_out && irq_request_out |=> irq_call_out && in_service_out;
  endproperty
  a_acc: assert property (p_acc) else $error("irq not taken");
  property p_idle; !instr_end_in |=> !irq_call_out; endproperty
  a_idle: assert property (p_idle) else $error("call off boundary");
  property p_nest; $past(in_service_out) |-> !irq_call_out; endproperty
  a_nest: assert property (p_nest) else $error("nested call");
  // In-service may only drop on an instruction boundary
  property p_fell; $fell(in_service_out) |-> $past(instr_end_in); endproperty
  a_fell: assert property (p_fell) else $error("early release");
  property p_gap; $fell(in_service_out) |-> !irq_call_out; endproperty
  a_gap: assert property (p_gap) else $error("no main instruction");
  property p_t2; timer2_ovf_in |=> irq_pending_out[6]; endproperty
  a_t2: assert property (p_t2) else $error("t2 lost");
  property p_t0; timer0_ovf_in |=> irq_pending_out[4]; endproperty
  a_t0: assert property (p_t0) else $error("t0 lost");
  property p_clr;
    reg_wr_in && reg_addr_in == 12'hf09 && !reg_wdata_in[6] && !timer2_ovf_in
      |=> !irq_pending_out[6];
  endproperty
  a_clr: assert property (p_clr) else $error("no clear");
  property p_hold;
    reg_wr_in && reg_addr_in == 12'hf09 && reg_wdata_in[4] && irq_pending_out[4]
      |=> irq_pending_out[4];
  endproperty
  a_hold: assert property (p_hold) else $error("flag lost");
  property p_esel;
    ctrl_wr_in && ctrl_addr_in == 8'h0b |=> ext_pin0_edge_sel_out == $past(ctrl_wdata_in[4]);
  endproperty
  a_esel: assert property (p_esel) else $error("bad select");
  property p_imp; !irq_pending_out[7] && !irq_pending_out[3]; endproperty
  a_imp: assert property (p_imp) else $error("unused bit set");
endmodule // sviu_top_props

// >>> sim/sviu_cpu_model.sv
module sviu_cpu_model (
  input  wire logic sys_clk_in,
  input  wire logic reset_n_in,
  input  wire logic irq_call_in,
  output logic      instr_end_out,
  output logic      ret_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] cnt_q;
  logic [1:0] isr_q;
  // Four-cycle instructions, two-instruction routine ending in a return
  // Return pulse shares the last cycle of the routine's final instruction
  always @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      cnt_q <= 2'h0;
      isr_q <= 2'h0;
      instr_end_out <= 1'b0;
      ret_out <= 1'b0;
    end else begin
      cnt_q <= cnt_q + 2'h1;
      instr_end_out <= (cnt_q == 2'h2);
      ret_out <= (cnt_q == 2'h2) && (isr_q == 2'h1);
      if (irq_call_in) begin
        isr_q <= 2'h2;
      end else if (instr_end_out && isr_q != 2'h0) begin
        isr_q <= isr_q - 2'h1;
      end
    end
  end
endmodule // sviu_cpu_model

// >>> sim/single_vector_interrupt_unit_tb.sv
module single_vector_interrupt_unit_tb;
  timeunit 1ns;
  timeprecision 1ps;
`define CHK(w, e, g) begin checks++; if ((e) !== (g)) begin n_errors++; \
  $display("wrong value %s exp %h got %h", w, e, g); end end
  logic        sys_clk_in = 1'b0;
  logic        reset_n_in = 1'b1;
  logic [11:0] reg_addr_in = 12'h000;
  logic        reg_wr_in = 1'b0;
  logic        reg_rd_in = 1'b0;
  logic [7:0]  reg_wdata_in = 8'h00;
  logic [7:0]  ctrl_addr_in = 8'h00;
  logic        ctrl_wr_in = 1'b0;
  logic [7:0]  ctrl_wdata_in = 8'h00;
  logic        timer2_ovf_in = 1'b0;
  logic        timer0_ovf_in = 1'b0;
  logic        comparator_in = 1'b0;
  logic        ext_pin2_in = 1'b1;
  logic        ext_pin1_in = 1'b1;
  logic        ext_pin0_in = 1'b1;
  logic        instr_end_in;
  logic        return_from_irq_in;
  logic [7:0]  reg_rdata_out;
  logic        irq_call_out;
  logic [10:0] irq_vector_out;
  logic        in_service_out;
  logic        irq_request_out;
  logic [7:0]  irq_pending_out;
  logic        ext_pin0_edge_sel_out;
  int          n_errors = 0;
  int          checks = 0;
  always #2.5 sys_clk_in = ~sys_clk_in;
  sviu_top dut_u (.*);
  sviu_cpu_model cpu_u (.sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in),
    .irq_call_in(irq_call_out), .instr_end_out(instr_end_in), .ret_out(return_from_irq_in));
  ////////////////////////////////////////
  task step; begin @(posedge sys_clk_in); #1; end endtask
  // Strobes drop for a cycle so back-to-back calls never reassign in one step
  task wr(input logic [11:0] a, input logic [7:0] d); begin
    reg_addr_in = a; reg_wdata_in = d; reg_wr_in = 1'b1; step; reg_wr_in = 1'b0; step;
  end endtask
  task rd(input logic [11:0] a, input logic [7:0] e); begin
    reg_addr_in = a; reg_rd_in = 1'b1; step; reg_rd_in = 1'b0; step;
    `CHK("rdata", e, reg_rdata_out)
  end endtask
  task ctl(input logic [7:0] a, input logic [7:0] d); begin
    ctrl_addr_in = a; ctrl_wdata_in = d; ctrl_wr_in = 1'b1; step; ctrl_wr_in = 1'b0; step;
  end endtask
  task report_and_stop; begin
    if (n_errors == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  end endtask
  task wait_for(input bit call);
    int i;
    begin
      for (i = 0; i < 200; i++) begin
        if (call ? irq_call_out === 1'b1 : in_service_out === 1'b0) return;
        step;
      end
      n_errors++;
      $display("wrong value wait exp event got timeout");
      report_and_stop;
    end
  endtask
  ////////////////////////////////////////
  task t_regs; begin
    rd(12'hf08, 8'h00);
    wr(12'hf08, 8'hff);
    rd(12'hf08, 8'h77);
    wr(12'hf0a, 8'hff);
    rd(12'hf0a, 8'h00);
    wr(12'hf08, 8'h00);
  end endtask
  task t_src; begin
    timer2_ovf_in = 1'b1; timer0_ovf_in = 1'b1; comparator_in = 1'b1;
    ext_pin2_in = 1'b0; ext_pin1_in = 1'b0; ext_pin0_in = 1'b0;
    step; timer2_ovf_in = 1'b0; timer0_ovf_in = 1'b0; step;
    `CHK("pend", 8'h77, irq_pending_out)
    `CHK("req", 1'b0, irq_request_out)
    wr(12'hf09, 8'hff);
    `CHK("pend", 8'h77, irq_pending_out)
    wr(12'hf09, 8'h00);
    `CHK("pend", 8'h00, irq_pending_out)
    ctl(8'h0b, 8'h10);
    ctl(8'h0c, 8'h00);
    `CHK("esel", 1'b1, ext_pin0_edge_sel_out)
    comparator_in = 1'b0; ext_pin2_in = 1'b1; ext_pin1_in = 1'b1; ext_pin0_in = 1'b1;
    step; step;
    rd(12'hf09, 8'h21);
    wr(12'hf09, 8'h00);
  end endtask
  task t_irq; begin
    wr(12'hf08, 8'h10);
    timer0_ovf_in = 1'b1; step; timer0_ovf_in = 1'b0;
    wait_for(1'b1);
    `CHK("insvc", 1'b1, in_service_out)
    `CHK("vec", 11'h001, irq_vector_out)
    wait_for(1'b0);
    repeat (3) begin
      step;
      `CHK("call", 1'b0, irq_call_out)
    end
    wait_for(1'b1);
    rd(12'hf09, 8'h10);
    wr(12'hf09, 8'hef);
    `CHK("req", 1'b0, irq_request_out)
    wait_for(1'b0);
    repeat (40) begin
      step;
      `CHK("call", 1'b0, irq_call_out)
    end
  end endtask
  task t_rst; begin
    wr(12'hf08, 8'h77);
    timer2_ovf_in = 1'b1; step; timer2_ovf_in = 1'b0;
    reset_n_in = 1'b0; step; step; reset_n_in = 1'b1; step;
    `CHK("pend", 8'h00, irq_pending_out)
    `CHK("insvc", 1'b0, in_service_out)
    `CHK("esel", 1'b0, ext_pin0_edge_sel_out)
    rd(12'hf08, 8'h00);
  end endtask
  initial begin
    reset_n_in = 1'b0;
    repeat (8) step;
    reset_n_in = 1'b1;
    step;
    t_regs;
    t_src;
    t_irq;
    t_rst;
    report_and_stop;
  end
endmodule // single_vector_interrupt_unit_tb
bind sviu_top sviu_top_props chk_u (.*);
